//--- hdl/agc_cfg.svh
// Purpose: Shared constants for the gain-loop and front-end configuration bank.
// Assumes: 32-bit APB data, one register per aligned word, byte address = index * 4.
// Notes: Field positions are given as msb/lsb pairs so the logic can select them by name.
`ifndef AGC_CFG_SVH
`define AGC_CFG_SVH

`define AGC_ADDR_W 20
`define AGC_SAMPLE_W 8
`define AGC_DATA_W 32

// Register indices; the byte address is the index shifted left by two.
`define AGC_IDX_GOAL 16'hDF17
`define AGC_IDX_SENSE 16'hDF18
`define AGC_IDX_GAIN_LOOP 16'hDF19
`define AGC_IDX_RX_TRIM 16'hDF1A
`define AGC_IDX_TX_TRIM 16'hDF1B
`define AGC_IDX_STATUS 16'hDF30

`define AGC_RST_GOAL 3'h3
`define AGC_RST_SENSE 4'h0
`define AGC_RST_GAIN_LOOP 8'h91
`define AGC_RST_RX_TRIM 8'h56
`define AGC_RST_TX_TRIM 8'h10

// Writable bits of the transmit trim register; the rest read as zero.
`define AGC_TX_WMASK 8'h37

`define AGC_DZ_MSB 7
`define AGC_DZ_LSB 6
`define AGC_WAIT_MSB 5
`define AGC_WAIT_LSB 4
`define AGC_HOLD_MSB 3
`define AGC_HOLD_LSB 2
`define AGC_LEN_MSB 1
`define AGC_LEN_LSB 0

// Carrier sense is switched off by the most negative threshold code.
`define AGC_THR_DISABLE 4'h8

// Settling unit in samples and the log2 of the shortest averaging length.
`define AGC_SETTLE_UNIT 6'h08
`define AGC_AVG_BASE_SHIFT 3

// Dead zone margins in dB below and above the goal for each dead zone code.
`define AGC_DZ0_LO 8'h01
`define AGC_DZ0_HI 8'h01
`define AGC_DZ1_LO 8'h01
`define AGC_DZ1_HI 8'h02
`define AGC_DZ2_LO 8'h02
`define AGC_DZ2_HI 8'h04
`define AGC_DZ3_LO 8'h04
`define AGC_DZ3_HI 8'h08

// Amplitude goal in dB for each goal code.
`define AGC_GOAL_DB0 8'h18
`define AGC_GOAL_DB1 8'h1B
`define AGC_GOAL_DB2 8'h1E
`define AGC_GOAL_DB3 8'h21
`define AGC_GOAL_DB4 8'h24
`define AGC_GOAL_DB5 8'h26
`define AGC_GOAL_DB6 8'h28
`define AGC_GOAL_DB7 8'h2A

// Status register layout.
`define AGC_ST_AVG_MSB 7
`define AGC_ST_AVG_LSB 0
`define AGC_ST_SENSE 8
`define AGC_ST_SYNC_HOLD 9
`define AGC_ST_SETTLING 10

`endif

//--- hdl/agc_frontend_config_regs.sv
// Purpose: APB register bank and gain-loop decision logic for the receiver gain control.
// Assumes: Amplitude samples and sync indication come from logic on i_ref_clk, in 1 dB units.
// Notes: The gain step outputs are one-cycle pulses; analog circuitry acts on them outside.
//
// Our own choice: register access over APB.
`default_nettype none
`include "agc_cfg.svh"
module agc_frontend_config_regs
	import agc_pkg::*;
#(
	parameter int SAMPLE_W = `AGC_SAMPLE_W
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [`AGC_ADDR_W-1:0] i_paddr,
	input wire logic [`AGC_DATA_W-1:0] i_pwdata,
	output logic [`AGC_DATA_W-1:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire amp_sample_t i_amp,
	input wire logic i_sync_found,
	input wire logic i_rx_restart,
	output gain_cmd_t o_gain_cmd,
	output logic o_carrier_sense,
	output fe_trim_t o_trim
);

	if (SAMPLE_W != `AGC_SAMPLE_W) begin : g_bad_width
		$error("SAMPLE_W must match the dB sample width of the goal table");
	end

	typedef struct packed {
		logic [2:0] goal;
		logic [3:0] sense_thr;
		logic [7:0] gain_loop;
		logic [7:0] rx_trim;
		logic [7:0] tx_trim;
		logic pready;
		logic pslverr;
		logic [`AGC_DATA_W-1:0] prdata;
		loop_state_t state;
		logic [5:0] settle_cnt;
		logic sync_hold;
		logic sense;
		logic [SAMPLE_W-1:0] last_avg;
		gain_cmd_t cmd;
	} top_state_t;

	top_state_t s_r, s_nxt;

	logic [5:0] sel;
	logic hit;
	logic avg_valid;
	logic [SAMPLE_W-1:0] avg;

	// Dead zone margin for a code; the upper margin is the wider one in the asymmetric codes.
	function automatic logic [7:0] dz_margin(input logic [1:0] code, input logic upper);
		logic [7:0] m;
		m = '0;
		case (code)
			2'b00: m = upper ? `AGC_DZ0_HI : `AGC_DZ0_LO;
			2'b01: m = upper ? `AGC_DZ1_HI : `AGC_DZ1_LO;
			2'b10: m = upper ? `AGC_DZ2_HI : `AGC_DZ2_LO;
			2'b11: m = upper ? `AGC_DZ3_HI : `AGC_DZ3_LO;
			default: m = '0;
		endcase
		return m;
	endfunction

	function automatic logic [7:0] goal_db(input logic [2:0] code);
		logic [7:0] d;
		d = '0;
		case (code)
			3'h0: d = `AGC_GOAL_DB0;
			3'h1: d = `AGC_GOAL_DB1;
			3'h2: d = `AGC_GOAL_DB2;
			3'h3: d = `AGC_GOAL_DB3;
			3'h4: d = `AGC_GOAL_DB4;
			3'h5: d = `AGC_GOAL_DB5;
			3'h6: d = `AGC_GOAL_DB6;
			3'h7: d = `AGC_GOAL_DB7;
			default: d = '0;
		endcase
		return d;
	endfunction

	agc_reg_decode u_decode (
		.i_paddr(i_paddr),
		.o_sel(sel),
		.o_hit(hit)
	);

	// The averager is held clear while settling so no stale samples enter the next block.
	amp_averager u_avg (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_clear(s_r.state != ST_ACCUM),
		.i_len(s_r.gain_loop[`AGC_LEN_MSB:`AGC_LEN_LSB]),
		.i_amp(i_amp),
		.o_avg_valid(avg_valid),
		.o_avg(avg)
	);

	logic [`AGC_DATA_W-1:0] rd_data;
	logic [1:0] dz_code;
	logic [1:0] wait_code;
	gain_hold_mode_t hold_mode;
	logic [9:0] goal_s;
	logic [9:0] thr_s;
	logic [9:0] avg_s;
	logic [9:0] upper_s;
	logic [9:0] lower_s;
	logic [5:0] settle_last;
	logic analog_free;
	logic digital_free;
	logic too_high;
	logic too_low;
	logic wr_access;

	always_comb begin
		dz_code = s_r.gain_loop[`AGC_DZ_MSB:`AGC_DZ_LSB];
		wait_code = s_r.gain_loop[`AGC_WAIT_MSB:`AGC_WAIT_LSB];
		hold_mode = gain_hold_mode_t'(s_r.gain_loop[`AGC_HOLD_MSB:`AGC_HOLD_LSB]);
		goal_s = {2'b00, goal_db(s_r.goal)};
		thr_s = goal_s + {{6{s_r.sense_thr[3]}}, s_r.sense_thr};
		avg_s = {{(10 - SAMPLE_W){1'b0}}, avg};
		upper_s = goal_s + {2'b00, dz_margin(dz_code, 1'b1)};
		lower_s = goal_s - {2'b00, dz_margin(dz_code, 1'b0)};
		settle_last = 6'(`AGC_SETTLE_UNIT * ({4'h0, wait_code} + 6'h01) - 6'h01);
		too_high = $signed(avg_s) > $signed(upper_s);
		too_low = $signed(avg_s) < $signed(lower_s);
		analog_free = 1'b0;
		digital_free = 1'b0;
		case (hold_mode)
			HOLD_NONE: begin
				analog_free = 1'b1;
				digital_free = 1'b1;
			end
			HOLD_ON_SYNC: begin
				analog_free = !s_r.sync_hold;
				digital_free = !s_r.sync_hold;
			end
			HOLD_ANALOG: begin
				analog_free = 1'b0;
				digital_free = 1'b1;
			end
			HOLD_ALL: begin
				analog_free = 1'b0;
				digital_free = 1'b0;
			end
			default: begin
				analog_free = 1'b0;
				digital_free = 1'b0;
			end
		endcase

		rd_data = '0;
		case (1'b1)
			sel[0]: rd_data[2:0] = s_r.goal;
			sel[1]: rd_data[3:0] = s_r.sense_thr;
			sel[2]: rd_data[7:0] = s_r.gain_loop;
			sel[3]: rd_data[7:0] = s_r.rx_trim;
			sel[4]: rd_data[7:0] = s_r.tx_trim & `AGC_TX_WMASK;
			sel[5]: begin
				rd_data[`AGC_ST_AVG_MSB:`AGC_ST_AVG_LSB] = s_r.last_avg;
				rd_data[`AGC_ST_SENSE] = s_r.sense;
				rd_data[`AGC_ST_SYNC_HOLD] = s_r.sync_hold;
				rd_data[`AGC_ST_SETTLING] = (s_r.state == ST_SETTLE);
			end
			default: rd_data = '0;
		endcase

		s_nxt = s_r;
		s_nxt.pready = 1'b0;
		s_nxt.pslverr = 1'b0;
		s_nxt.cmd = '0;
		// Read data stands only with pready, so a stale word never sits on the bus between transfers.
		s_nxt.prdata = '0;

		// The answer is prepared in the setup cycle so pready stands in the first access cycle.
		if (i_psel && !i_penable) begin
			s_nxt.pready = 1'b1;
			s_nxt.pslverr = !hit;
			s_nxt.prdata = (hit && !i_pwrite) ? rd_data : '0;
		end

		wr_access = i_psel && i_penable && s_r.pready && i_pwrite && !s_r.pslverr;
		if (wr_access) begin
			if (sel[0]) begin
				s_nxt.goal = i_pwdata[2:0];
			end
			if (sel[1]) begin
				s_nxt.sense_thr = i_pwdata[3:0];
			end
			if (sel[2]) begin
				s_nxt.gain_loop = i_pwdata[7:0];
			end
			if (sel[3]) begin
				s_nxt.rx_trim = i_pwdata[7:0];
			end
			if (sel[4]) begin
				// Bits outside AGC_TX_WMASK are stored as zero, whatever software writes to them.
				s_nxt.tx_trim = i_pwdata[7:0] & `AGC_TX_WMASK;
			end
		end

		// A sync word in the cycle of a restart still freezes the gain.
		if (i_rx_restart) begin
			s_nxt.sync_hold = 1'b0;
		end
		if (i_sync_found && hold_mode == HOLD_ON_SYNC) begin
			s_nxt.sync_hold = 1'b1;
		end

		case (s_r.state)
			ST_ACCUM: begin
				if (avg_valid) begin
					s_nxt.last_avg = avg;
					s_nxt.sense = (s_r.sense_thr != `AGC_THR_DISABLE) &&
						($signed(avg_s) >= $signed(thr_s));
					if (too_high || too_low) begin
						if (analog_free) begin
							s_nxt.cmd.analog_step = 1'b1;
							s_nxt.cmd.analog_up = too_low;
						end else if (digital_free) begin
							s_nxt.cmd.digital_step = 1'b1;
							s_nxt.cmd.digital_up = too_low;
						end
						if (analog_free || digital_free) begin
							s_nxt.state = ST_SETTLE;
							s_nxt.settle_cnt = '0;
						end
					end
				end
			end
			ST_SETTLE: begin
				if (i_amp.valid) begin
					if (s_r.settle_cnt >= settle_last) begin
						s_nxt.state = ST_ACCUM;
						s_nxt.settle_cnt = '0;
					end else begin
						s_nxt.settle_cnt = s_r.settle_cnt + 6'h01;
					end
				end
			end
			default: begin
				s_nxt.state = ST_ACCUM;
				s_nxt.settle_cnt = '0;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			s_r <= '0;
			s_r.goal <= `AGC_RST_GOAL;
			s_r.sense_thr <= `AGC_RST_SENSE;
			s_r.gain_loop <= `AGC_RST_GAIN_LOOP;
			s_r.rx_trim <= `AGC_RST_RX_TRIM;
			s_r.tx_trim <= `AGC_RST_TX_TRIM;
			s_r.state <= ST_ACCUM;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_prdata = s_r.prdata;
	assign o_pready = s_r.pready;
	assign o_pslverr = s_r.pslverr;
	assign o_gain_cmd = s_r.cmd;
	assign o_carrier_sense = s_r.sense;
	assign o_trim.input_amp_bias = s_r.rx_trim[7:6];
	assign o_trim.amp_to_mixer_bias = s_r.rx_trim[5:4];
	assign o_trim.rx_oscillator_buffer_bias = s_r.rx_trim[3:2];
	assign o_trim.mixer_bias = s_r.rx_trim[1:0];
	assign o_trim.tx_oscillator_buffer_bias = s_r.tx_trim[5:4];
endmodule // agc_frontend_config_regs
`default_nettype wire

//--- hdl/agc_pkg.sv
// Purpose: Types shared by the gain-loop configuration bank and its helpers.
// Assumes: agc_cfg.svh supplies the sample width; the accumulator, counter, enum and trim field widths are fixed here.
// Notes: Holds types only; numbers live in the header.
`default_nettype none
`include "agc_cfg.svh"
package agc_pkg;

	typedef enum logic [1:0] {
		ST_ACCUM = 2'b01,
		ST_SETTLE = 2'b10
	} loop_state_t;

	typedef enum logic [1:0] {
		HOLD_NONE = 2'b00,
		HOLD_ON_SYNC = 2'b01,
		HOLD_ANALOG = 2'b10,
		HOLD_ALL = 2'b11
	} gain_hold_mode_t;

	typedef struct packed {
		logic valid;
		logic [`AGC_SAMPLE_W-1:0] value;
	} amp_sample_t;

	typedef struct packed {
		logic analog_step;
		logic analog_up;
		logic digital_step;
		logic digital_up;
	} gain_cmd_t;

	typedef struct packed {
		logic [1:0] input_amp_bias;
		logic [1:0] amp_to_mixer_bias;
		logic [1:0] rx_oscillator_buffer_bias;
		logic [1:0] mixer_bias;
		logic [1:0] tx_oscillator_buffer_bias;
	} fe_trim_t;

	typedef struct packed {
		logic [13:0] acc;
		logic [6:0] cnt;
		logic vld;
		logic [`AGC_SAMPLE_W-1:0] avg;
	} avg_state_t;

endpackage
`default_nettype wire

//--- hdl/agc_reg_decode.sv
// Purpose: Maps an APB byte address onto the register select lines.
// Assumes: Registers sit on aligned words; the low two address bits must be zero.
// Notes: Purely combinational; the caller registers whatever it derives.
`default_nettype none
`include "agc_cfg.svh"
module agc_reg_decode (
	input wire logic [`AGC_ADDR_W-1:0] i_paddr,
	output logic [5:0] o_sel,
	output logic o_hit
);
	localparam logic [15:0] IDX [6] = '{`AGC_IDX_GOAL, `AGC_IDX_SENSE, `AGC_IDX_GAIN_LOOP,
		`AGC_IDX_RX_TRIM, `AGC_IDX_TX_TRIM, `AGC_IDX_STATUS};

	for (genvar g = 0; g < 6; g++) begin : g_sel
		assign o_sel[g] = (i_paddr == {2'b00, IDX[g], 2'b00});
	end

	assign o_hit = |o_sel;
endmodule // agc_reg_decode
`default_nettype wire

//--- hdl/amp_averager.sv
// Purpose: Averages channel-filter amplitude samples over 8, 16, 32 or 64 samples.
// Assumes: Samples arrive from logic on the same clock.
// Notes: A clear drops the partial sum, so a block never mixes samples from before a gain step.
`default_nettype none
`include "agc_cfg.svh"
module amp_averager
	import agc_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_clear,
	input wire logic [1:0] i_len,
	input wire amp_sample_t i_amp,
	output logic o_avg_valid,
	output logic [`AGC_SAMPLE_W-1:0] o_avg
);
	avg_state_t s_r, s_nxt;
	logic [6:0] last_cnt;
	logic [13:0] sum;

	always_comb begin
		s_nxt = s_r;
		s_nxt.vld = 1'b0;
		last_cnt = 7'((7'h01 << (`AGC_AVG_BASE_SHIFT + 32'(i_len))) - 7'h01);
		sum = s_r.acc + 14'(i_amp.value);
		if (i_clear) begin
			s_nxt.acc = '0;
			s_nxt.cnt = '0;
		end else if (i_amp.valid) begin
			if (s_r.cnt == last_cnt) begin
				s_nxt.avg = `AGC_SAMPLE_W'(sum >> (`AGC_AVG_BASE_SHIFT + 32'(i_len)));
				s_nxt.vld = 1'b1;
				s_nxt.acc = '0;
				s_nxt.cnt = '0;
			end else begin
				s_nxt.acc = sum;
				s_nxt.cnt = s_r.cnt + 7'h01;
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_avg_valid = s_r.vld;
	assign o_avg = s_r.avg;
endmodule // amp_averager
`default_nettype wire

//--- tb/agc_regs_assertions.sv
// Purpose: Port checker for the gain-loop configuration bank.
// Assumes: One clock domain; the hold mode is mirrored from completed APB writes.
// Notes: Bound to the top module at the foot of this file.
`default_nettype none
`include "agc_cfg.svh"
module agc_regs_chk
	import agc_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [`AGC_ADDR_W-1:0] i_paddr,
	input wire logic [`AGC_DATA_W-1:0] i_pwdata,
	input wire logic [`AGC_DATA_W-1:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire amp_sample_t i_amp,
	input wire logic i_sync_found,
	input wire logic i_rx_restart,
	input wire gain_cmd_t o_gain_cmd,
	input wire logic o_carrier_sense,
	input wire fe_trim_t o_trim
);
	logic [1:0] hold_r;
	logic [1:0] hold_nxt;
	logic step;
	assign step = o_gain_cmd.analog_step || o_gain_cmd.digital_step;
	always_comb begin
		hold_nxt = hold_r;
		if (i_psel && i_penable && i_pwrite && o_pready && !o_pslverr
			&& i_paddr == 20'({`AGC_IDX_GAIN_LOOP, 2'b00})) begin
			hold_nxt = i_pwdata[3:2];
		end
	end
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			hold_r <= 2'b00;
		end else begin
			hold_r <= hold_nxt;
		end
	end
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);
	sequence s_setup;
		i_psel && !i_penable;
	endsequence
	sequence s_access;
		i_psel && i_penable;
	endsequence
	AST_READY_AFTER_SETUP: assert property (s_setup |=> o_pready)
		else $error("ready missing after setup");
	AST_READY_ONLY_ACCESS: assert property (o_pready |-> $past(i_psel && !i_penable) ##0 s_access)
		else $error("ready outside first access cycle");
	AST_ERR_WITH_READY: assert property (o_pslverr |-> o_pready)
		else $error("error without ready");
	AST_RDATA_IDLE_ZERO: assert property (!o_pready |-> o_prdata == '0)
		else $error("read data not zero when idle");
	AST_TRIM_RESET: assert property ($fell(i_rst) |-> o_trim == 10'h159)
		else $error("trim reset value wrong");
	AST_FREEZE_ALL: assert property (hold_r == 2'b11 && $stable(hold_r) |-> !step)
		else $error("gain step while fully frozen");
	AST_FREEZE_ANALOG: assert property (hold_r == 2'b10 && $stable(hold_r) |-> !o_gain_cmd.analog_step)
		else $error("analog step while analog frozen");
	AST_STEP_PULSE: assert property (step |=> !step)
		else $error("gain step longer than one cycle");
	AST_ONE_STEP_KIND: assert property (!(o_gain_cmd.analog_step && o_gain_cmd.digital_step))
		else $error("analog and digital step together");
	AST_STEP_FROM_SAMPLE: assert property (step |-> $past(i_amp.valid, 2))
		else $error("gain step not two cycles after a sample");
endmodule // agc_regs_chk
bind agc_frontend_config_regs agc_regs_chk i_chk (.i_ref_clk, .i_rst, .i_psel, .i_penable, .i_pwrite,
	.i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_amp, .i_sync_found, .i_rx_restart,
	.o_gain_cmd, .o_carrier_sense, .o_trim);
`default_nettype wire

//--- tb/tb_agc_frontend_config_regs.sv
// Purpose: Self-checking bench for the gain-loop configuration bank.
// Assumes: Zero wait-state APB slave; samples are in dB.
// Notes: Averages use alternating v, v+1 samples so truncation is exercised.
`default_nettype none
`include "agc_cfg.svh"
module tb_agc_frontend_config_regs import agc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [19:0] A_GOAL = 20'({`AGC_IDX_GOAL, 2'b00});
	localparam logic [19:0] A_THR = 20'({`AGC_IDX_SENSE, 2'b00});
	localparam logic [19:0] A_GL = 20'({`AGC_IDX_GAIN_LOOP, 2'b00});
	localparam logic [19:0] A_RX = 20'({`AGC_IDX_RX_TRIM, 2'b00});
	localparam logic [19:0] A_TX = 20'({`AGC_IDX_TX_TRIM, 2'b00});
	localparam logic [19:0] A_ST = 20'({`AGC_IDX_STATUS, 2'b00});
	localparam logic [15:0] CS_TAB [8] = '{16'h7235, 16'h7232, 16'h6E51, 16'h6E4E, 16'h6043, 16'h7190,
		16'h0031, 16'hFE50};
	localparam logic [31:0] GT [21] = '{32'h0008_2200, 32'h0008_2000, 32'h3008_2308, 32'h301F_1400,
		32'h3001_1400, 32'h3008_140C, 32'h0820_2100, 32'h0808_2302, 32'hC808_2100, 32'hC808_2900,
		32'hC808_1D00, 32'hC808_1C03, 32'h0408_2100, 32'h0408_2300, 32'h0408_2308, 32'h4808_2100,
		32'h4808_2300, 32'hA808_1E03, 32'hA817_1E00, 32'hA801_1E00, 32'hA808_1E03};
	logic ref_clk, rst, psel, penable, pwrite, sync, restart, pready, pslverr, cs;
	logic [19:0] paddr;
	logic [31:0] pwdata, prdata, rdat, g;
	logic rerr;
	amp_sample_t amp;
	gain_cmd_t gain_cmd, seen;
	fe_trim_t trim;
	logic [15:0] t;
	logic [8:0] prev;
	logic [7:0] v;
	int num_errors = 0;
	int checks = 0;
	int cyc = 0;
	agc_frontend_config_regs i_dut (.i_ref_clk(ref_clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .i_amp(amp), .i_sync_found(sync), .i_rx_restart(restart),
		.o_gain_cmd(gain_cmd), .o_carrier_sense(cs), .o_trim(trim));
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	task automatic results();
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			num_errors++;
			results();
		end
	end
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] got);
		checks++;
		if (got !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %0h seen %0h", s, e, got);
		end
	endtask
	// The request is held until ready is seen, then released for one idle cycle.
	task automatic apb(input logic w, input logic [19:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do
			@(posedge ref_clk);
		while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic wr(input logic [19:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input string s, input logic [19:0] a, input logic [31:0] e, input logic er);
		apb(1'b0, a, '0);
		chk(s, e, rdat);
		chk(s, 32'(er), 32'(rerr));
	endtask
	task automatic feed(input int n, input logic [7:0] val);
		seen = '0;
		for (int i = 0; i < n; i++) begin
			amp <= '{1'b1, val + 8'(i & 1)};
			@(posedge ref_clk);
		end
		amp <= '{1'b0, val};
		repeat (4) begin
			@(posedge ref_clk);
			seen = gain_cmd_t'(seen | gain_cmd);
		end
	endtask
	initial begin
		{rst, psel, penable, pwrite, sync, restart} = 6'b100000;
		paddr = '0;
		pwdata = '0;
		amp = '0;
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		rd("goal", A_GOAL, 32'h3, 1'b0);
		rd("thr", A_THR, 32'h0, 1'b0);
		rd("loop", A_GL, 32'h91, 1'b0);
		rd("rx", A_RX, 32'h56, 1'b0);
		rd("tx", A_TX, 32'h10, 1'b0);
		chk("trim", 32'h159, 32'(trim));
		$display("reset values done");
		wr(A_TX, 32'hFFFF_FFF8);
		rd("tx", A_TX, 32'h30, 1'b0);
		wr(A_RX, 32'hFFFF_FF1B);
		rd("rx", A_RX, 32'h1B, 1'b0);
		chk("trim", 32'h06F, 32'(trim));
		wr(20'h37C70, 32'h1);
		wr(A_ST, 32'hFFFF_FFFF);
		rd("status", A_ST, 32'h0, 1'b0);
		rd("unmapped", 20'h37C70, 32'h0, 1'b1);
		rd("misaligned", A_GL + 20'h1, 32'h0, 1'b1);
		$display("access kinds done");
		wr(A_GL, 32'h0C);
		foreach (CS_TAB[k]) begin
			t = CS_TAB[k];
			wr(A_GOAL, 32'(t[15:13]));
			wr(A_THR, 32'(t[12:9]));
			feed(8, t[8:1]);
			chk("sense", 32'(t[0]), 32'(cs));
			rd("status", A_ST, {23'h0, t[0], t[8:1]}, 1'b0);
			chk("steps", 32'h0, 32'(seen));
		end
		prev = {t[0], t[8:1]};
		wr(A_GOAL, 32'h3);
		wr(A_THR, 32'h0);
		for (int L = 0; L < 4; L++) begin
			v = 8'(40 + 10 * L);
			wr(A_GL, 32'h0C + 32'(L));
			feed((8 << L) - 1, v);
			rd("partial", A_ST, 32'(prev), 1'b0);
			feed(1, v);
			prev = {1'b1, v};
			rd("average", A_ST, 32'(prev), 1'b0);
		end
		$display("sense and averaging done");
		foreach (GT[k]) begin
			g = GT[k];
			wr(A_GL, 32'(g[31:24]));
			if (k == 13)
				sync <= 1'b1;
			if (k == 14)
				restart <= 1'b1;
			@(posedge ref_clk);
			sync <= 1'b0;
			restart <= 1'b0;
			feed(int'(g[23:16]), g[15:8]);
			chk("gain step", 32'(g[3:0]), 32'(seen));
			if (k == 2)
				rd("settling", A_ST, 32'h523, 1'b0);
			if (k == 13)
				rd("sync hold", A_ST, 32'h323, 1'b0);
		end
		$display("gain loop done");
		results();
	end
endmodule // tb_agc_frontend_config_regs
`default_nettype wire
